// >>> rtl/ebpc_defines.svh
// constant names for the external bus pin control block
`ifndef EBPC_DEFINES_SVH
`define EBPC_DEFINES_SVH
`define EBPC_AW          23
`define EBPC_AW_LO       16
`define EBPC_DW          16
`define EBPC_REG_AW      4
`define EBPC_OFS_BANK    4'h0
`define EBPC_OFS_STATUS  4'h4
`define EBPC_BIT_DHOLD   1
`define EBPC_BANK_RST    32'h0000_0002
`define EBPC_BANK_MASK   32'h0000_0002
`define EBPC_ST_HOLDA    0
`define EBPC_ST_HOST     1
`define EBPC_ST_OFF      2
`define EBPC_ST_BUSY     3
`define EBPC_ZERO32      32'h0000_0000
`define EBPC_UPPER_ZERO  7'h00
`endif

// >>> rtl/ebpc_pkg.sv
// types shared by the external bus pin control block
package ebpc_pkg;
  typedef enum logic [1:0] {
    EBPC_SP_PROG,
    EBPC_SP_DATA,
    EBPC_SP_IO
  } ebpc_space_t;

  typedef struct packed {
    ebpc_space_t  space;
    logic         write;
    logic [22:0]  addr;
    logic [15:0]  wdata;
  } ebpc_acc_t;

  typedef enum logic [1:0] {
    EBPC_IDLE,
    EBPC_ADDR,
    EBPC_XFER
  } ebpc_state_t;
endpackage

// >>> rtl/ebpc_bus_holder.sv
// bus holder model: keeps last level of each line while it floats
`timescale 1ns/1ps
`include "ebpc_defines.svh"
module ebpc_bus_holder #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_oe_next,
  input  wire logic [W-1:0] i_drv_next,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_keep_en,
  output logic      [W-1:0] o_keep_val
);
  logic [W-1:0] keep_en_reg;
  logic [W-1:0] keep_val_reg;
  logic [W-1:0] oe_reg;
  logic [W-1:0] drv_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      oe_reg  <= '0;
      drv_reg <= '0;
    end else begin
      oe_reg  <= i_oe_next;
      drv_reg <= i_drv_next;
    end
  end

  // holder takes over in the same cycle the driver lets go
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      keep_en_reg  <= '0;
      keep_val_reg <= '0;
    end else begin
      keep_en_reg  <= {W{i_en}} & ~i_oe_next;
      keep_val_reg <= (oe_reg & drv_reg) | (~oe_reg & i_pin);
    end
  end

  assign o_keep_en  = keep_en_reg;
  assign o_keep_val = keep_val_reg;
endmodule

// >>> rtl/ebpc_hold_arb.sv
// hold request arbitration against the external access sequencer
`timescale 1ns/1ps
module ebpc_hold_arb (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_hold_n,
  input  wire logic i_bus_idle,
  output logic      o_holda
);
  logic holda_reg;

  // grant only between accesses so no cycle is cut in half
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      holda_reg <= 1'b0;
    end else if (i_hold_n) begin
      holda_reg <= 1'b0;
    end else if (i_bus_idle) begin
      holda_reg <= 1'b1;
    end
  end

  assign o_holda = holda_reg;
endmodule

// >>> rtl/ebpc_top.sv
// external parallel bus pin control with avalon-mm register slave
// Summary of operation
// - low sixteen address lines drive every access
// - upper seven lines extend program accesses only
// - address floats in hold or output disable
// - host wide mode makes low address inputs
// - address holders keep last level when floating
// - data lines carry core or host transfers
// - data floats unless writing, reset, hold, off
// - software bit enables data bus holders
// - hold request granted, then lines float
`timescale 1ns/1ps
`include "ebpc_defines.svh"
module ebpc_top (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic [`EBPC_REG_AW-1:0] i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic      [31:0]             o_avs_readdata,
  output logic                         o_avs_waitrequest,
  input  wire logic                    i_acc_valid,
  input  wire ebpc_pkg::ebpc_acc_t     i_acc,
  output logic                         o_acc_ready,
  output logic                         o_acc_done,
  output logic      [`EBPC_DW-1:0]     o_acc_rdata,
  input  wire logic                    i_hold_n,
  output logic                         o_holda_n,
  input  wire logic                    i_off_n,
  input  wire logic                    i_host_port_wide_mode_select,
  input  wire logic                    i_ready,
  output logic                         o_rw,
  output logic                         o_strobe_n,
  output logic                         o_ctrl_oe,
  input  wire logic [`EBPC_AW-1:0]     i_addr_in,
  output logic      [`EBPC_AW-1:0]     o_addr_out,
  output logic      [`EBPC_AW-1:0]     o_addr_oe,
  output logic      [`EBPC_AW-1:0]     o_addr_keep_en,
  output logic      [`EBPC_AW-1:0]     o_addr_keep_val,
  input  wire logic [`EBPC_DW-1:0]     i_data_in,
  output logic      [`EBPC_DW-1:0]     o_data_out,
  output logic      [`EBPC_DW-1:0]     o_data_oe,
  output logic      [`EBPC_DW-1:0]     o_data_keep_en,
  output logic      [`EBPC_DW-1:0]     o_data_keep_val,
  output logic      [`EBPC_AW_LO-1:0]  o_host_addr,
  output logic      [`EBPC_DW-1:0]     o_host_data
);
  ebpc_pkg::ebpc_state_t state_reg;
  ebpc_pkg::ebpc_state_t state_next;
  ebpc_pkg::ebpc_acc_t   acc_reg;

  logic [31:0]           bank_reg;
  logic [31:0]           rdata_reg;
  logic                  wait_reg;
  logic                  ready_reg;
  logic                  done_reg;
  logic [`EBPC_DW-1:0]   rdata_acc_reg;
  logic                  rw_reg;
  logic                  strobe_n_reg;
  logic                  ctrl_oe_reg;
  logic [`EBPC_AW-1:0]   addr_out_reg;
  logic [`EBPC_AW-1:0]   addr_oe_reg;
  logic [`EBPC_DW-1:0]   data_out_reg;
  logic [`EBPC_DW-1:0]   data_oe_reg;
  logic [`EBPC_AW_LO-1:0] host_addr_reg;
  logic [`EBPC_DW-1:0]   host_data_reg;

  logic                  holda;
  logic                  bus_free;
  logic                  start;
  logic                  pins_on;
  logic                  bus_ack;
  logic                  bus_wr;
  logic [`EBPC_AW-1:0]   addr_next;
  logic [`EBPC_AW-1:0]   addr_oe_next;
  logic [`EBPC_DW-1:0]   data_oe_next;
  logic [`EBPC_DW-1:0]   data_next;
  logic [31:0]           status;
  logic [31:0]           bank_wmask;

  // ---------------------------------------------------------------
  // register slave: one wait cycle, then waitrequest low one cycle
  // ---------------------------------------------------------------
  assign bus_ack = (i_avs_read | i_avs_write) & wait_reg;
  assign bus_wr  = i_avs_write & ~wait_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_reg <= 1'b1;
    end else if (bus_ack) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign status = {28'h0000000,
                   state_reg != ebpc_pkg::EBPC_IDLE,
                   ~i_off_n,
                   i_host_port_wide_mode_select,
                   holda};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= `EBPC_ZERO32;
    end else if (bus_ack && i_avs_read) begin
      case (i_avs_address)
        `EBPC_OFS_BANK:   rdata_reg <= bank_reg;
        `EBPC_OFS_STATUS: rdata_reg <= status;
        default:          rdata_reg <= `EBPC_ZERO32;
      endcase
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_be
      assign bank_wmask[gb*8 +: 8] = {8{i_avs_byteenable[gb]}};
    end
  endgenerate

  // only the holder enable bit is writable; others read zero
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bank_reg <= `EBPC_BANK_RST;
    end else if (bus_wr && i_avs_address == `EBPC_OFS_BANK) begin
      bank_reg <= ((bank_reg & ~bank_wmask) | (i_avs_writedata & bank_wmask))
                  & `EBPC_BANK_MASK;
    end
  end

  // ---------------------------------------------------------------
  // hold arbitration
  // ---------------------------------------------------------------
  ebpc_hold_arb u_hold (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_hold_n   (i_hold_n),
    .i_bus_idle (state_reg == ebpc_pkg::EBPC_IDLE),
    .o_holda    (holda)
  );

  // ---------------------------------------------------------------
  // external access sequencer
  // ---------------------------------------------------------------
  // no new access once hold is asked for, so the grant is not starved
  assign bus_free = ~holda & i_hold_n & ~i_host_port_wide_mode_select;
  assign start    = i_acc_valid & ready_reg & bus_free;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ebpc_pkg::EBPC_IDLE: begin
        if (start) begin
          state_next = ebpc_pkg::EBPC_ADDR;
        end
      end
      ebpc_pkg::EBPC_ADDR: begin
        state_next = ebpc_pkg::EBPC_XFER;
      end
      ebpc_pkg::EBPC_XFER: begin
        if (i_ready) begin
          state_next = ebpc_pkg::EBPC_IDLE;
        end
      end
      default: begin
        state_next = ebpc_pkg::EBPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ebpc_pkg::EBPC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_reg <= '0;
    end else if (start) begin
      acc_reg <= i_acc;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == ebpc_pkg::EBPC_IDLE) & ~start;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_reg      <= 1'b0;
      rdata_acc_reg <= '0;
    end else begin
      done_reg <= (state_reg == ebpc_pkg::EBPC_XFER) & i_ready;
      if (state_reg == ebpc_pkg::EBPC_XFER && i_ready && !acc_reg.write) begin
        rdata_acc_reg <= i_data_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // off low wins over everything, including a write in flight
  assign pins_on = i_off_n & ~holda;

  // upper lines only carry program space addresses
  assign addr_next = (acc_reg.space == ebpc_pkg::EBPC_SP_PROG)
                     ? acc_reg.addr
                     : {`EBPC_UPPER_ZERO, acc_reg.addr[`EBPC_AW_LO-1:0]};

  genvar ga;
  generate
    for (ga = 0; ga < `EBPC_AW; ga++) begin : g_aoe
      if (ga < `EBPC_AW_LO) begin : g_lo
        assign addr_oe_next[ga] = pins_on & ~i_host_port_wide_mode_select;
      end else begin : g_hi
        assign addr_oe_next[ga] = pins_on;
      end
    end
  endgenerate

  assign data_oe_next = {`EBPC_DW{pins_on & acc_reg.write
                                  & (state_next == ebpc_pkg::EBPC_XFER)}};
  assign data_next    = acc_reg.wdata;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_out_reg <= '0;
      addr_oe_reg  <= '0;
      data_out_reg <= '0;
      data_oe_reg  <= '0;
    end else begin
      addr_out_reg <= addr_next;
      addr_oe_reg  <= addr_oe_next;
      data_out_reg <= data_next;
      data_oe_reg  <= data_oe_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rw_reg       <= 1'b1;
      strobe_n_reg <= 1'b1;
      ctrl_oe_reg  <= 1'b0;
    end else begin
      rw_reg       <= ~(acc_reg.write & (state_next != ebpc_pkg::EBPC_IDLE));
      strobe_n_reg <= state_next != ebpc_pkg::EBPC_XFER;
      ctrl_oe_reg  <= pins_on;
    end
  end

  // host side: wide mode samples the low sixteen address lines and data as host inputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      host_addr_reg <= '0;
      host_data_reg <= '0;
    end else if (i_host_port_wide_mode_select) begin
      host_addr_reg <= i_addr_in[`EBPC_AW_LO-1:0];
      host_data_reg <= i_data_in;
    end
  end

  // ---------------------------------------------------------------
  // bus holders: address always on, data under software control
  // ---------------------------------------------------------------
  ebpc_bus_holder #(
    .W (`EBPC_AW)
  ) u_addr_keep (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_en       (1'b1),
    .i_oe_next  (addr_oe_next),
    .i_drv_next (addr_next),
    .i_pin      (i_addr_in),
    .o_keep_en  (o_addr_keep_en),
    .o_keep_val (o_addr_keep_val)
  );

  ebpc_bus_holder #(
    .W (`EBPC_DW)
  ) u_data_keep (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_en       (bank_reg[`EBPC_BIT_DHOLD]),
    .i_oe_next  (data_oe_next),
    .i_drv_next (data_next),
    .i_pin      (i_data_in),
    .o_keep_en  (o_data_keep_en),
    .o_keep_val (o_data_keep_val)
  );

  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_acc_ready       = ready_reg;
  assign o_acc_done        = done_reg;
  assign o_acc_rdata       = rdata_acc_reg;
  assign o_holda_n         = ~holda;
  assign o_rw              = rw_reg;
  assign o_strobe_n        = strobe_n_reg;
  assign o_ctrl_oe         = ctrl_oe_reg;
  assign o_addr_out        = addr_out_reg;
  assign o_addr_oe         = addr_oe_reg;
  assign o_data_out        = data_out_reg;
  assign o_data_oe         = data_oe_reg;
  assign o_host_addr       = host_addr_reg;
  assign o_host_data       = host_data_reg;
endmodule

// >>> test/ebpc_ext_mem.sv
// external memory model behind the parallel bus
`timescale 1ns/1ps
module ebpc_ext_mem (
  input  wire logic        i_clk,
  input  wire logic        i_strobe_n,
  input  wire logic        i_rw,
  input  wire logic        i_slow,
  input  wire logic [22:0] i_addr,
  input  wire logic [15:0] i_data_out,
  input  wire logic [15:0] i_data_oe,
  input  wire logic [15:0] i_keep_en,
  input  wire logic [15:0] i_keep_val,
  input  wire logic        i_ext_drv,
  input  wire logic [15:0] i_ext_val,
  output logic             o_ready,
  output logic [15:0]      o_data_pin,
  output logic [22:0]      o_last_addr
);
  logic [15:0] mem [16];
  logic [15:0] prev = 16'h0;
  logic        waited = 1'b0;
  logic        rd;
  logic [15:0] flt;
  assign rd = !i_strobe_n && i_rw;
  // undriven bits with no holder show the inverse of the last level, never a stale copy
  assign flt = i_ext_drv ? i_ext_val : rd ? mem[i_addr[3:0]] :
               (i_keep_en & i_keep_val) | (~i_keep_en & ~prev);
  assign o_data_pin = (i_data_oe & i_data_out) | (~i_data_oe & flt);
  assign o_ready = i_strobe_n | ~i_slow | waited;
  always @(posedge i_clk) begin
    prev <= o_data_pin;
    waited <= !i_strobe_n;
    if (!i_strobe_n && o_ready) o_last_addr <= i_addr;
    if (!i_strobe_n && o_ready && !i_rw) mem[i_addr[3:0]] <= o_data_pin;
  end
endmodule

// >>> test/ebpc_top_props.sv
// concurrent checks on the external bus pin control ports
`timescale 1ns/1ps
module ebpc_top_props (
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_acc_valid,
  input  wire ebpc_pkg::ebpc_acc_t i_acc,
  input  wire logic                o_acc_ready,
  input  wire logic                o_acc_done,
  input  wire logic                i_hold_n,
  input  wire logic                o_holda_n,
  input  wire logic                i_off_n,
  input  wire logic                i_host_port_wide_mode_select,
  input  wire logic                o_rw,
  input  wire logic                o_strobe_n,
  input  wire logic                o_ctrl_oe,
  input  wire logic [22:0]         o_addr_out,
  input  wire logic [22:0]         o_addr_oe,
  input  wire logic [22:0]         o_addr_keep_en,
  input  wire logic [15:0]         o_data_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic tk;
  assign tk = i_acc_valid & o_acc_ready & i_hold_n & o_holda_n & ~i_host_port_wide_mode_select;
  // address flop follows the captured access one edge after the take
  chk_addr_space_map: assert property (tk |-> ##2 o_addr_out ==
    {($past(i_acc.space, 2) == ebpc_pkg::EBPC_SP_PROG) ? $past(i_acc.addr[22:16], 2) : 7'h00,
     $past(i_acc.addr[15:0], 2)}) else $error("address lines wrong for access");
  chk_off_float: assert property (!i_off_n |=> o_addr_oe == 23'h0
    && o_data_oe == 16'h0 && !o_ctrl_oe) else $error("pins driven while off");
  chk_hold_float: assert property (!o_holda_n |=> o_addr_oe == 23'h0
    && o_data_oe == 16'h0 && !o_ctrl_oe) else $error("pins driven in hold");
  chk_host_addr_in: assert property (i_host_port_wide_mode_select |=>
    o_addr_oe[15:0] == 16'h0) else $error("low address driven in host mode");
  chk_addr_keep_on: assert property ($past(i_resetn) |->
    o_addr_keep_en == ~o_addr_oe) else $error("address holder mismatch");
  chk_data_write_only: assert property (o_data_oe != 16'h0 |-> !o_rw && !o_strobe_n)
    else $error("data driven outside write");
  chk_done_time: assert property (tk |-> ##1 !o_acc_done [*2] ##[1:40] o_acc_done)
    else $error("access done timing wrong");
  chk_write_dir: assert property (tk && i_acc.write |-> ##2 !o_rw)
    else $error("direction not write");
endmodule
bind ebpc_top ebpc_top_props u_props (.i_clk, .i_resetn, .i_acc_valid, .i_acc, .o_acc_ready,
  .o_acc_done, .i_hold_n, .o_holda_n, .i_off_n, .i_host_port_wide_mode_select, .o_rw,
  .o_strobe_n, .o_ctrl_oe, .o_addr_out, .o_addr_oe, .o_addr_keep_en, .o_data_oe);

// >>> test/test_external_bus_pin_control.sv
// self-checking bench for the external bus pin control block
`timescale 1ns/1ps
module test_external_bus_pin_control;
  logic                i_clk = 1'b0, i_resetn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0]          i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
  logic [31:0]         i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic                o_avs_waitrequest, i_acc_valid = 1'b0, o_acc_ready, o_acc_done;
  ebpc_pkg::ebpc_acc_t i_acc = '0;
  logic [15:0]         o_acc_rdata, i_data_in, o_data_out, o_data_oe, o_data_keep_en;
  logic [15:0]         o_data_keep_val, o_host_addr, o_host_data, wd;
  logic                i_hold_n = 1'b1, o_holda_n, i_off_n = 1'b1, i_ready, slow = 1'b0;
  logic                i_host_port_wide_mode_select = 1'b0, o_rw, o_strobe_n, o_ctrl_oe;
  logic [22:0]         i_addr_in, o_addr_out, o_addr_oe, o_addr_keep_en, o_addr_keep_val;
  logic [22:0]         aprev = 23'h0, afl, last_addr, a;
  int                  n_mismatch = 0, compares = 0;
  always #20 i_clk = ~i_clk;
  assign afl = (o_addr_keep_en & o_addr_keep_val) | (~o_addr_keep_en & ~aprev);
  // host only drives the low lines, upper ones come from the block or its holder
  assign i_addr_in = (o_addr_oe & o_addr_out) | (~o_addr_oe &
    (i_host_port_wide_mode_select ? {afl[22:16], 16'h1234} : afl));
  always @(posedge i_clk) aprev <= i_addr_in;
  ebpc_top dut (.i_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_acc_valid, .i_acc,
    .o_acc_ready, .o_acc_done, .o_acc_rdata, .i_hold_n, .o_holda_n, .i_off_n,
    .i_host_port_wide_mode_select, .i_ready, .o_rw, .o_strobe_n, .o_ctrl_oe, .i_addr_in,
    .o_addr_out, .o_addr_oe, .o_addr_keep_en, .o_addr_keep_val, .i_data_in, .o_data_out,
    .o_data_oe, .o_data_keep_en, .o_data_keep_val, .o_host_addr, .o_host_data);
  ebpc_ext_mem u_mem (.i_clk, .i_strobe_n(o_strobe_n), .i_rw(o_rw), .i_slow(slow),
    .i_addr(o_addr_out), .i_data_out(o_data_out), .i_data_oe(o_data_oe),
    .i_keep_en(o_data_keep_en), .i_keep_val(o_data_keep_val),
    .i_ext_drv(i_host_port_wide_mode_select), .i_ext_val(16'hbeef), .o_ready(i_ready),
    .o_data_pin(i_data_in), .o_last_addr(last_addr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic avs(input logic wr, input logic [3:0] ad, input logic [31:0] wdat);
    @(posedge i_clk);
    i_avs_address <= ad;
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_writedata <= wdat;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic acc(input ebpc_pkg::ebpc_space_t sp, input logic wr);
    do @(posedge i_clk); while (o_acc_ready !== 1'b1);
    i_acc_valid <= 1'b1;
    i_acc <= '{sp, wr, a, wd};
    do @(posedge i_clk); while (o_acc_ready !== 1'b1);
    i_acc_valid <= 1'b0;
    do @(posedge i_clk); while (o_acc_done !== 1'b1);
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400us;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    avs(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h2);
    avs(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      slow <= i[0];
      a = {7'h4b, 12'h0, 4'(i)};
      wd = 16'ha5c0 + 16'(i);
      acc(ebpc_pkg::ebpc_space_t'(i), 1'b1);
      chk(32'(last_addr), (i == 0) ? 32'(a) : 32'(a[15:0]));
      chk(32'(o_data_keep_val), 32'(wd));
      acc(ebpc_pkg::ebpc_space_t'(i), 1'b0);
      chk(32'(o_acc_rdata), 32'(wd));
    end
    $display("test accesses done");
    avs(1'b1, 4'h0, 32'h0);
    repeat (2) @(posedge i_clk);
    chk(32'(o_data_keep_en), 32'h0);
    avs(1'b1, 4'h0, 32'h2);
    repeat (2) @(posedge i_clk);
    chk(32'(o_data_keep_en), 32'hffff);
    // a write with no lane enabled must leave the holder bit alone
    i_avs_byteenable <= 4'h0;
    avs(1'b1, 4'h0, 32'h0);
    i_avs_byteenable <= 4'hf;
    avs(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h2);
    $display("test holder enable done");
    i_hold_n <= 1'b0;
    do @(posedge i_clk); while (o_holda_n !== 1'b0);
    repeat (2) @(posedge i_clk);
    chk(32'(o_addr_oe), 32'h0);
    chk(32'(o_data_oe), 32'h0);
    chk(32'(o_addr_keep_val), 32'h2);
    avs(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h1);
    i_hold_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    $display("test hold done");
    i_off_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(32'(o_addr_oe), 32'h0);
    chk(32'(o_ctrl_oe), 32'h0);
    avs(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h4);
    i_off_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(32'(o_addr_oe), 32'h7fffff);
    $display("test output disable done");
    i_host_port_wide_mode_select <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(32'(o_addr_oe), 32'h7f0000);
    chk(32'(o_host_addr), 32'h1234);
    chk(32'(o_host_data), 32'hbeef);
    avs(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h2);
    i_host_port_wide_mode_select <= 1'b0;
    $display("test host mode done");
    @(posedge i_clk);
    i_resetn <= 1'b0;
    @(posedge i_clk);
    chk(32'(o_data_oe), 32'h0);
    chk(32'(o_holda_n), 32'h1);
    i_resetn <= 1'b1;
    avs(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h2);
    $display("test second reset done");
    give_verdict;
  end
endmodule
